// [hdl/ees_cfg.svh]
`ifndef EES_CFG_SVH
`define EES_CFG_SVH

// device address byte layout
`define EES_TYPE_HI      7
`define EES_TYPE_LO      4
`define EES_STRAP_HI_BIT 3
`define EES_STRAP_LO_BIT 2
`define EES_MSB_BIT      1
`define EES_RW_BIT       0

// byte framing: bit clocks per byte before the acknowledge slot
`define EES_BYTE_BITS    4'h8
`define EES_CNT_W        4

// storage geometry
`define EES_PAGES        32
`define EES_PAGE_BYTES   16
`define EES_ADDR_W       9
`define EES_DATA_W       8

// pin synchroniser: {busy, strap hi, strap lo, scl, sda}
`define EES_SYNC_W       5
`define EES_SYNC_INIT    5'h03
`define EES_PIN_BUSY     4
`define EES_PIN_SHI      3
`define EES_PIN_SLO      2
`define EES_PIN_SCL      1
`define EES_PIN_SDA      0

`endif

// [hdl/ees_pkg.sv]
`include "ees_cfg.svh"

package ees_pkg;

  typedef logic [`EES_ADDR_W-1:0] ees_addr_t;
  typedef logic [`EES_DATA_W-1:0] ees_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_DEV_ACK,
    ST_WORDADDR,
    ST_DATA_IN,
    ST_IN_ACK,
    ST_DATA_OUT,
    ST_OUT_ACK,
    ST_PROG
  } ees_state_e;

endpackage

// [hdl/ees_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module ees_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // two stages; the first is read only by the second
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta <= INIT;
      q_o  <= INIT;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

// [hdl/ees_xfer.sv]
`timescale 1ns/100ps
`default_nettype none

module ees_xfer #(
  parameter int W = 9
) (
  input  wire logic         src_clock_i,
  input  wire logic         src_rst_i,
  input  wire logic         src_valid_i,
  input  wire logic [W-1:0] src_data_i,
  input  wire logic         dst_clock_i,
  input  wire logic         dst_rst_i,
  output logic              dst_pulse_o,
  output logic      [W-1:0] dst_data_o
);

  logic         tog;
  logic         next_tog;
  logic [W-1:0] hold;
  logic [W-1:0] next_hold;
  logic         tog_s;
  logic         tog_q;
  logic         next_pulse;
  logic [W-1:0] next_data;

  // source side: word is held still while the toggle crosses
  always_comb begin
    next_tog  = tog ^ src_valid_i;
    next_hold = src_valid_i ? src_data_i : hold;
  end

  always_ff @(posedge src_clock_i) begin
    if (src_rst_i) begin
      tog  <= '0;
      hold <= '0;
    end else begin
      tog  <= next_tog;
      hold <= next_hold;
    end
  end

  ees_sync #(.W(1), .INIT(1'b0)) u_tog_sync (
    .clock_i (dst_clock_i),
    .rst_i   (dst_rst_i),
    .d_i     (tog),
    .q_o     (tog_s)
  );

  // destination: a toggle edge means the held word is settled
  always_comb begin
    next_pulse = tog_s ^ tog_q;
    next_data  = next_pulse ? hold : dst_data_o;
  end

  always_ff @(posedge dst_clock_i) begin
    if (dst_rst_i) begin
      tog_q       <= '0;
      dst_pulse_o <= '0;
      dst_data_o  <= '0;
    end else begin
      tog_q       <= tog_s;
      dst_pulse_o <= next_pulse;
      dst_data_o  <= next_data;
    end
  end

endmodule

`default_nettype wire

// [hdl/ees_front.sv]
// Operation
// - transmitter frees SDA at the falling edge ending the eighth bit clock
// - receiver acknowledges by holding SDA low through the ninth clock high
// - receiver frees SDA when the ninth clock ends
// - on a master no-acknowledge the device frees SDA so a Stop can follow
// - after reset the device sits in standby
// - a Stop returns to standby unless it launches a programming cycle
// - standby follows as soon as a programming cycle finishes
// - a device address mismatch returns to standby
// - a master no-acknowledge after read data returns to standby
// - Start, nine clocks, Start then Stop leaves the device idle
// - storage is 32 pages of 16 bytes, 9-bit byte address
// - every access opens with an 8-bit device address byte after Start
// - upper four address bits must equal the fixed type identifier
// - bits 3 and 2 must equal the two strap address inputs
// - bit 1 of the device address byte is the byte address MSB
// - bit 0 selects direction: high read, low write
// - acknowledge on match, no acknowledge and standby on mismatch
// - a word address byte, MSB first, follows except for current reads
// - sample SDA on SCL rise, change output on SCL fall
// - bytes travel MSB first, one bit per SCL clock
// - Start is SDA falling with SCL high, Stop is SDA rising with SCL high
`timescale 1ns/100ps
`default_nettype none
`include "ees_cfg.svh"

module ees_front #(
  parameter logic [3:0] DEV_TYPE_ID = 4'h6  // arbitrary value
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              mem_clock_i,
  input  wire logic              mem_rst_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire logic              strap_addr_hi_i,
  input  wire logic              strap_addr_lo_i,
  input  wire logic              prog_busy_i,
  input  wire ees_pkg::ees_byte_t rd_data_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  output logic                   standby_o,
  output ees_pkg::ees_addr_t     addr_o,
  output logic                   rd_req_o,
  output ees_pkg::ees_byte_t     wr_data_o,
  output logic                   wr_valid_o,
  output logic                   mem_prog_start_o,
  output ees_pkg::ees_addr_t     mem_prog_addr_o
);
  import ees_pkg::*;

  logic [`EES_SYNC_W-1:0] pin_s;
  logic                   scl_s;
  logic                   sda_s;
  logic                   busy_s;
  logic                   scl_q;
  logic                   sda_q;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_ev;
  logic                   stop_ev;
  logic                   dev_match;

  ees_state_e             state;
  ees_state_e             next_state;
  logic [`EES_CNT_W-1:0]  cnt;
  logic [`EES_CNT_W-1:0]  next_cnt;
  ees_byte_t              shreg;
  ees_byte_t              next_shreg;
  logic                   rw;
  logic                   next_rw;
  logic                   has_data;
  logic                   next_has_data;
  logic                   seen_busy;
  logic                   next_seen_busy;
  logic                   prog_go;
  logic                   next_prog_go;
  ees_addr_t              next_addr;
  logic                   next_oe;
  logic                   next_rd_req;
  ees_byte_t              next_wr_data;
  logic                   next_wr_valid;

  // every pin crosses two flops before anything looks at it
  ees_sync #(.W(`EES_SYNC_W), .INIT(`EES_SYNC_INIT)) u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({prog_busy_i, strap_addr_hi_i, strap_addr_lo_i, scl_i, sda_i}),
    .q_o     (pin_s)
  );

  assign scl_s  = pin_s[`EES_PIN_SCL];
  assign sda_s  = pin_s[`EES_PIN_SDA];
  assign busy_s = pin_s[`EES_PIN_BUSY];

  // bus events from synchronised levels only
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

  // identifier and straps; straps are synchronised like any pin
  assign dev_match =
    (shreg[`EES_TYPE_HI:`EES_TYPE_LO] == DEV_TYPE_ID) &&
    (shreg[`EES_STRAP_HI_BIT] == pin_s[`EES_PIN_SHI]) &&
    (shreg[`EES_STRAP_LO_BIT] == pin_s[`EES_PIN_SLO]);

  // protocol engine; a Start wins over everything but programming
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_rw        = rw;
    next_has_data  = has_data;
    next_seen_busy = seen_busy;
    next_prog_go   = 1'b0;
    next_addr      = addr_o;
    next_oe        = sda_oe_o;
    next_rd_req    = 1'b0;
    next_wr_data   = wr_data_o;
    next_wr_valid  = 1'b0;
    if (state != ST_PROG && start_ev) begin
      next_state    = ST_DEVADDR;
      next_cnt      = '0;
      next_oe       = 1'b0;
      next_has_data = 1'b0;
    end else if (state != ST_PROG && stop_ev) begin
      next_oe = 1'b0;
      if (!rw && has_data) begin
        next_state     = ST_PROG;
        next_prog_go   = 1'b1;
        next_seen_busy = 1'b0;
        next_has_data  = 1'b0;  // a stray Stop after programming must not relaunch it
      end else begin
        next_state = ST_IDLE;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          next_oe = 1'b0;
        end
        ST_DEVADDR, ST_WORDADDR, ST_DATA_IN: begin
          if (scl_rise && cnt != `EES_BYTE_BITS) begin
            next_shreg = {shreg[`EES_DATA_W-2:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == `EES_BYTE_BITS) begin
            if (state == ST_DEVADDR) begin
              if (dev_match) begin
                next_rw = shreg[`EES_RW_BIT];
                next_addr[`EES_ADDR_W-1] = shreg[`EES_MSB_BIT];
                next_oe    = 1'b1;
                next_state = ST_DEV_ACK;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_WORDADDR) begin
              next_addr[`EES_DATA_W-1:0] = shreg;
              next_oe    = 1'b1;
              next_state = ST_IN_ACK;
            end else begin
              next_wr_data  = shreg;
              next_wr_valid = 1'b1;
              next_has_data = 1'b1;
              next_oe       = 1'b1;
              next_state    = ST_IN_ACK;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            next_cnt = '0;
            if (rw) begin
              // current address read: first byte goes out at once
              next_shreg  = rd_data_i;
              next_rd_req = 1'b1;
              next_oe     = ~rd_data_i[`EES_DATA_W-1];
              next_state  = ST_DATA_OUT;
            end else begin
              next_oe    = 1'b0;
              next_state = ST_WORDADDR;
            end
          end
        end
        ST_IN_ACK: begin
          if (scl_fall) begin
            next_oe    = 1'b0;
            next_cnt   = '0;
            next_state = ST_DATA_IN;
          end
        end
        ST_DATA_OUT: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == `EES_BYTE_BITS) begin
              next_oe    = 1'b0;
              next_addr  = addr_o + 9'h001;  // whole-array roll over
              next_state = ST_OUT_ACK;
            end else begin
              next_shreg = {shreg[`EES_DATA_W-2:0], 1'b0};
              next_oe    = ~shreg[`EES_DATA_W-2];
            end
          end
        end
        ST_OUT_ACK: begin
          if (scl_rise && sda_s) begin
            next_oe    = 1'b0;
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            next_cnt    = '0;
            next_shreg  = rd_data_i;
            next_rd_req = 1'b1;
            next_oe     = ~rd_data_i[`EES_DATA_W-1];
            next_state  = ST_DATA_OUT;
          end
        end
        ST_PROG: begin
          // bus is deaf; wait for busy to rise and then to fall
          next_oe = 1'b0;
          if (busy_s) begin
            next_seen_busy = 1'b1;
          end
          if (seen_busy && !busy_s) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  // registers; reset lands in standby with the line released
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      state      <= ST_IDLE;
      cnt        <= '0;
      shreg      <= '0;
      rw         <= '0;
      has_data   <= '0;
      seen_busy  <= '0;
      prog_go    <= '0;
      addr_o     <= '0;
      sda_oe_o   <= '0;
      sda_o      <= '0;
      standby_o  <= 1'b1;
      rd_req_o   <= '0;
      wr_data_o  <= '0;
      wr_valid_o <= '0;
    end else begin
      scl_q      <= scl_s;
      sda_q      <= sda_s;
      state      <= next_state;
      cnt        <= next_cnt;
      shreg      <= next_shreg;
      rw         <= next_rw;
      has_data   <= next_has_data;
      seen_busy  <= next_seen_busy;
      prog_go    <= next_prog_go;
      addr_o     <= next_addr;
      sda_oe_o   <= next_oe;
      sda_o      <= '0;  // open drain: only the enable carries data
      standby_o  <= (next_state == ST_IDLE);
      rd_req_o   <= next_rd_req;
      wr_data_o  <= next_wr_data;
      wr_valid_o <= next_wr_valid;
    end
  end

  // programming request crosses into the storage clock domain
  ees_xfer #(.W(`EES_ADDR_W)) u_prog_xfer (
    .src_clock_i (clock_i),
    .src_rst_i   (rst_i),
    .src_valid_i (prog_go),
    .src_data_i  (addr_o),
    .dst_clock_i (mem_clock_i),
    .dst_rst_i   (mem_rst_i),
    .dst_pulse_o (mem_prog_start_o),
    .dst_data_o  (mem_prog_addr_o)
  );

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_start_restart: assert property (
    (state != ST_PROG && start_ev) |=> (state == ST_DEVADDR && cnt == '0 && !sda_oe_o))
    else $error("start did not restart address reception");
  chk_stop_standby: assert property (
    (state != ST_PROG && !start_ev && stop_ev && (rw || !has_data))
      |=> (state == ST_IDLE && standby_o))
    else $error("stop did not return to standby");
  chk_mismatch_idle: assert property (
    (state == ST_DEVADDR && !start_ev && !stop_ev && scl_fall &&
     cnt == `EES_BYTE_BITS && !dev_match) |=> (state == ST_IDLE && !sda_oe_o))
    else $error("mismatching address was not refused");
  chk_ack_held: assert property (
    (state == ST_DEV_ACK || state == ST_IN_ACK) |-> sda_oe_o)
    else $error("acknowledge not driven low");
  chk_ack_release: assert property (
    (state == ST_IN_ACK && scl_fall && !start_ev && !stop_ev)
      |=> (!sda_oe_o && state == ST_DATA_IN))
    else $error("acknowledge not released after ninth clock");
  chk_eighth_release: assert property (
    (state == ST_DATA_OUT && scl_fall && cnt == `EES_BYTE_BITS && !start_ev && !stop_ev)
      |=> (!sda_oe_o && state == ST_OUT_ACK))
    else $error("transmitter kept SDA after eighth clock");
  chk_nack_standby: assert property (
    (state == ST_OUT_ACK && scl_rise && sda_s && !start_ev && !stop_ev)
      |=> (state == ST_IDLE && !sda_oe_o) ##1 standby_o)
    else $error("no-acknowledge did not end the read");
  chk_drive_on_fall: assert property (
    $rose(sda_oe_o) |-> $past(scl_fall))
    else $error("SDA driven away from a falling SCL edge");
  chk_prog_done: assert property (
    (state == ST_PROG && seen_busy && !busy_s) |=> (state == ST_IDLE))
    else $error("no standby after programming finished");
  chk_addr_msb: assert property (
    (state == ST_DEVADDR && !start_ev && !stop_ev && scl_fall &&
     cnt == `EES_BYTE_BITS && dev_match)
      |=> (addr_o[`EES_ADDR_W-1] == $past(shreg[`EES_MSB_BIT]) && sda_oe_o))
    else $error("address MSB not taken from device byte");

  cov_read_nack: cover property (state == ST_OUT_ACK && scl_rise && sda_s);
  cov_write_prog: cover property (state == ST_PROG ##1 state == ST_IDLE);
  cov_mismatch: cover property (state == ST_DEVADDR ##1 state == ST_IDLE);
  cov_seq_read: cover property (state == ST_OUT_ACK ##1 state == ST_DATA_OUT);

endmodule

`default_nettype wire

// [bench/ees_master.sv]
`timescale 1ns/100ps
`default_nettype none

// bus master model: drives scl, pulls sda low through an open-drain enable
module ees_master (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  int clash = 0; // released line seen low while scl high

  // idle bus: both lines high
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // waits whole internal cycles, then steps off the edge
  task automatic ph(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // start condition, usable from idle or as a repeated start with scl low
  task automatic bus_start();
    ph(2); // never move sda in the same step as an scl fall
    sda_oe_o = 1'b0;
    ph(10);
    scl_o = 1'b1;
    ph(12);
    sda_oe_o = 1'b1;
    ph(12);
    scl_o = 1'b0;
  endtask

  task automatic bus_stop();
    ph(2);
    sda_oe_o = 1'b1;
    ph(10);
    scl_o = 1'b1;
    ph(12);
    sda_oe_o = 1'b0;
    ph(12);
  endtask

  // top n bits of b, data changed only two cycles after scl falls
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      ph(2);
      sda_oe_o = !b[i];
      ph(10);
      scl_o = 1'b1;
      ph(6);
      if (!sda_oe_o && sda_i !== 1'b1) clash++;
      ph(6);
      scl_o = 1'b0;
    end
  endtask

  // whole byte, then ack slot; ack is 0 only if low through the high phase
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic a;
    send_bits(b, 8);
    ph(2);
    sda_oe_o = 1'b0;
    ph(10);
    scl_o = 1'b1;
    ph(2);
    a = sda_i;
    ph(9);
    ack = a | sda_i;
    ph(1);
    scl_o = 1'b0;
  endtask

  // reads a byte, then answers with ack or nack in the ninth clock
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ph(12);
      scl_o = 1'b1;
      ph(6);
      b[i] = sda_i;
      ph(6);
      scl_o = 1'b0;
    end
    ph(2);
    sda_oe_o = !nack;
    ph(10);
    scl_o = 1'b1;
    ph(6);
    if (nack && sda_i !== 1'b1) clash++;
    ph(6);
    scl_o = 1'b0;
    ph(2);
    sda_oe_o = 1'b0;
  endtask

  // bare clocks with sda released, as in bus recovery
  task automatic clocks(input int n);
    ph(2);
    sda_oe_o = 1'b0;
    repeat (n) begin
      ph(12);
      scl_o = 1'b1;
      ph(12);
      scl_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb;
  import ees_pkg::*;
  localparam logic [3:0] TYPE_ID = 4'h6; // arbitrary value
  localparam logic [7:0] DEV_W   = {TYPE_ID, 4'h6}; // straps 0/1, address msb 1, write
  localparam logic [7:0] DEV_R   = {TYPE_ID, 4'h7};

  logic      clock_i = 0, rst_i = 1, mem_clock_i = 0, mem_rst_i = 1;
  logic      prog_busy = 0, strap_hi = 0, strap_lo = 1, ack;
  logic      scl, m_oe, dev_oe, standby, rd_req, wr_valid, prog_start, sda_out;
  logic      [7:0] b;
  ees_addr_t addr, prog_addr, prog_seen;
  ees_byte_t rd_data, wr_data, wr_seen;
  int        err_total = 0, comparisons = 0, rd_reqs = 0, prog_starts = 0;
  wire logic sda_line = !(dev_oe | m_oe); // pull-up wins when nobody pulls

  // storage stand-in: each address holds 0xc3 xor its low byte xor its MSB
  function automatic ees_byte_t exp_rd(input ees_addr_t a);
    return 8'hc3 ^ a[7:0] ^ {7'h00, a[8]};
  endfunction
  assign rd_data = exp_rd(addr);

  ees_front #(.DEV_TYPE_ID(TYPE_ID)) ees_front_inst (
    .clock_i(clock_i), .rst_i(rst_i), .mem_clock_i(mem_clock_i), .mem_rst_i(mem_rst_i),
    .scl_i(scl), .sda_i(sda_line), .strap_addr_hi_i(strap_hi), .strap_addr_lo_i(strap_lo),
    .prog_busy_i(prog_busy), .rd_data_i(rd_data), .sda_o(sda_out), .sda_oe_o(dev_oe),
    .standby_o(standby), .addr_o(addr), .rd_req_o(rd_req), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid), .mem_prog_start_o(prog_start), .mem_prog_addr_o(prog_addr));

  ees_master ees_master_inst (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(m_oe));

  // two unrelated clocks: 4 ns internal, 30 ns storage side
  initial forever #2 clock_i = ~clock_i;
  initial begin
    #7;
    forever #15 mem_clock_i = ~mem_clock_i;
  end

  // pulse monitors keep what the one-cycle strobes carried
  always @(posedge clock_i) begin
    if (wr_valid === 1'b1) wr_seen <= wr_data;
    if (rd_req === 1'b1) rd_reqs <= rd_reqs + 1;
  end
  always @(posedge mem_clock_i) begin
    if (prog_start === 1'b1) begin
      prog_seen   <= prog_addr;
      prog_starts <= prog_starts + 1;
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // bounded wait for the engine to fall idle
  task automatic wait_standby();
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 400) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (standby !== 1'b1) begin
      err_total++;
      $display("[ERR] standby_wait expected 1 seen %b", standby);
      end_of_test();
    end
  endtask

  task automatic t_reset();
    `CHK("standby", 1'b1, standby)
    `CHK("sda_oe", 1'b0, dev_oe)
    `CHK("addr", 9'h000, addr)
    `CHK("sda_o", 1'b0, sda_out)
  endtask

  // wrong type, wrong high strap, wrong low strap
  task automatic t_mismatch();
    logic [7:0] bad [3];
    bad = '{{TYPE_ID ^ 4'h1, 4'h4}, {TYPE_ID, 4'hc}, {TYPE_ID, 4'h0}};
    for (int i = 0; i < 3; i++) begin
      ees_master_inst.bus_start();
      ees_master_inst.send_byte(bad[i], ack);
      `CHK("mismatch_ack", 1'b1, ack)
      `CHK("mismatch_standby", 1'b1, standby)
      ees_master_inst.bus_stop();
    end
  endtask

  task automatic t_write();
    ees_master_inst.bus_start();
    ees_master_inst.send_byte(DEV_W, ack);
    `CHK("dev_ack", 1'b0, ack)
    ees_master_inst.send_byte(8'h3c, ack);
    `CHK("word_ack", 1'b0, ack)
    `CHK("addr", 9'h13c, addr)
    ees_master_inst.send_byte(8'ha5, ack);
    `CHK("data_ack", 1'b0, ack)
    `CHK("wr_data", 8'ha5, wr_seen)
    ees_master_inst.bus_stop();
    ees_master_inst.ph(60);
    `CHK("prog_starts", 1, prog_starts)
    `CHK("prog_page", 5'h13, prog_seen[8:4])
    `CHK("prog_addr", 9'h13c, prog_seen)
    `CHK("busy_standby", 1'b0, standby)
    // the device ignores the bus while programming
    ees_master_inst.bus_start();
    ees_master_inst.send_byte(DEV_W, ack);
    `CHK("busy_ack", 1'b1, ack)
    ees_master_inst.bus_stop();
    prog_busy = 1'b1;
    ees_master_inst.ph(40);
    prog_busy = 1'b0;
    wait_standby();
    `CHK("prog_done_standby", 1'b1, standby)
  endtask

  // random read at the top address, second byte wraps to zero
  task automatic t_read();
    ees_master_inst.bus_start();
    ees_master_inst.send_byte(DEV_W, ack);
    ees_master_inst.send_byte(8'hff, ack);
    `CHK("word_ack", 1'b0, ack)
    ees_master_inst.bus_start();
    ees_master_inst.send_byte(DEV_R, ack);
    `CHK("read_ack", 1'b0, ack)
    `CHK("sda_level", 1'b0, sda_out)
    ees_master_inst.recv_byte(1'b0, b);
    `CHK("rd_byte0", exp_rd(9'h1ff), b)
    ees_master_inst.recv_byte(1'b1, b);
    `CHK("rd_byte1", exp_rd(9'h000), b)
    wait_standby();
    `CHK("nack_standby", 1'b1, standby)
    `CHK("nack_release", 1'b0, dev_oe)
    `CHK("rd_reqs", 2, rd_reqs)
    ees_master_inst.bus_stop();
  endtask

  // aborted byte, recovery sequence, then a start inside a byte
  task automatic t_recover();
    ees_master_inst.bus_start();
    ees_master_inst.send_bits(DEV_W, 4);
    ees_master_inst.bus_start();
    ees_master_inst.clocks(9);
    ees_master_inst.bus_start();
    ees_master_inst.bus_stop();
    `CHK("recover_standby", 1'b1, standby)
    ees_master_inst.bus_start();
    ees_master_inst.send_bits(DEV_W, 3);
    ees_master_inst.bus_start();
    ees_master_inst.send_byte(DEV_W, ack);
    `CHK("restart_ack", 1'b0, ack)
    ees_master_inst.bus_stop();
    wait_standby();
    `CHK("stop_standby", 1'b1, standby)
  endtask

  // strapless package: both strap pins low, master sends zeros there
  task automatic t_no_straps();
    strap_lo = 1'b0;
    ees_master_inst.ph(10);
    ees_master_inst.bus_start();
    ees_master_inst.send_byte({TYPE_ID, 4'h0}, ack);
    `CHK("zero_strap_ack", 1'b0, ack)
    ees_master_inst.bus_stop();
    wait_standby();
    `CHK("zero_strap_standby", 1'b1, standby)
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge clock_i);
    err_total++;
    $display("[ERR] run_length expected finish seen timeout");
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    repeat (40) @(posedge clock_i);
    #1;
    mem_rst_i = 1'b0;
    ees_master_inst.ph(10);
    t_mismatch();
    t_write();
    t_read();
    t_recover();
    t_no_straps();
    `CHK("bus_clash", 0, ees_master_inst.clash)
    end_of_test();
  end
endmodule
`default_nettype wire
